// ==== logic/eccl_pkg.sv ====
// Constants and types for the configuration latch and program control block
package eccl_pkg;

   // Timing
   localparam int unsigned ECCL_CLK_PERIOD_NS = 10;
   localparam int unsigned ECCL_PROG_TIME_MS  = 10;
   localparam int unsigned ECCL_PROG_CYCLES   =
      ECCL_PROG_TIME_MS * 1000000 / ECCL_CLK_PERIOD_NS;
   localparam int unsigned ECCL_CNT_W         = 24;
   localparam logic [1:0]  ECCL_SYNC_WAIT     = 2'h2;

   // Register indices; byte address is four times the index
   localparam logic [15:0] ECCL_IDX_PROG      = 16'h103B;
   localparam logic [15:0] ECCL_IDX_CFG       = 16'h103F;
   localparam logic [15:0] ECCL_IDX_STAT      = 16'h1040;
   localparam logic [15:0] ECCL_IDX_ARR       = 16'hB600;
   localparam logic [15:0] ECCL_IDX_NONE      = 16'hFFFF;
   localparam int unsigned ECCL_ARR_BYTES     = 512;
   localparam int unsigned ECCL_ARR_AW        = 9;
   localparam int unsigned ECCL_ROW_LSB       = 4;

   // Program control fields
   localparam int unsigned ECCL_PC_BYTE       = 4;
   localparam int unsigned ECCL_PC_ROW        = 3;
   localparam int unsigned ECCL_PC_ERASE      = 2;
   localparam int unsigned ECCL_PC_LAT        = 1;
   localparam int unsigned ECCL_PC_HV         = 0;
   localparam logic [7:0]  ECCL_PC_MASK       = 8'hDF;
   localparam logic [7:0]  ECCL_PC_RST        = 8'h00;

   // Configuration fields
   localparam int unsigned ECCL_CFG_SECURITY_DISABLE     = 3;
   localparam int unsigned ECCL_CFG_WATCHDOG_DISABLE     = 2;
   localparam int unsigned ECCL_CFG_ROM_ENABLE     = 1;
   localparam int unsigned ECCL_CFG_ARRAY_ENABLE      = 0;
   localparam logic [3:0]  ECCL_CFG_LAT_RST   = 4'hF;
   localparam logic [7:0]  ECCL_NV_ERASED     = 8'hFF;

   typedef enum logic [1:0] {
      ECCL_SINGLE   = 2'b00,
      ECCL_EXPANDED = 2'b01,
      ECCL_BOOT     = 2'b10,
      ECCL_TEST     = 2'b11
   } eccl_mode_t;

   typedef enum logic [1:0] {
      ECCL_WAIT  = 2'b00,
      ECCL_LOAD  = 2'b01,
      ECCL_SCRUB = 2'b10,
      ECCL_RUN   = 2'b11
   } eccl_seq_t;

endpackage : eccl_pkg

// ==== logic/eccl_sync2.sv ====
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module eccl_sync2 #(
   parameter int unsigned WIDTH = 2
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= '0;
         s2_r <= '0;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
      end
   end

   assign q = s2_r;

endmodule : eccl_sync2

// ==== logic/eccl_nv_store.sv ====
// Nonvolatile array and stored configuration byte
`timescale 1ns/1ns
module eccl_nv_store
   import eccl_pkg::*;
#(
   parameter int unsigned ARR_BYTES = ECCL_ARR_BYTES,
   parameter int unsigned AW        = ECCL_ARR_AW
) (
   input  wire logic          clk,
   input  wire logic          por_n,
   input  wire logic          op_valid,
   input  wire logic          op_cfg,
   input  wire logic          op_erase,
   input  wire logic          op_byte,
   input  wire logic          op_row,
   input  wire logic [AW-1:0] op_idx,
   input  wire logic [7:0]    op_data,
   input  wire logic [AW-1:0] rd_idx,
   output logic      [7:0]    rd_data,
   output logic      [7:0]    cfg_data
);
   logic [7:0] arr_q [ARR_BYTES];
   logic [7:0] cfg_r;
   logic [7:0] cfg_nxt;

   genvar gi;
   generate
      for (gi = 0; gi < ARR_BYTES; gi++) begin : g_ent
         logic [7:0] ent_r;
         logic [7:0] ent_nxt;
         logic       hit_b;
         logic       hit_row;
         always_comb begin
            hit_b   = (op_idx == AW'(gi));
            hit_row = ((op_idx >> ECCL_ROW_LSB) == (AW'(gi) >> ECCL_ROW_LSB));
            ent_nxt = ent_r;
            if (op_valid && op_erase && (op_cfg || (!op_byte && !op_row)
                || (op_byte && hit_b) || (op_row && hit_row))) begin
               ent_nxt = ECCL_NV_ERASED;
            end else if (op_valid && !op_erase && !op_cfg && hit_b) begin
               ent_nxt = ent_r & op_data;
            end
         end
         always_ff @(posedge clk or negedge por_n) begin
            if (!por_n) begin
               ent_r <= ECCL_NV_ERASED;
            end else begin
               ent_r <= ent_nxt;
            end
         end
         assign arr_q[gi] = ent_r;
      end
   endgenerate

   always_comb begin
      cfg_nxt = cfg_r;
      if (op_valid && op_cfg) begin
         cfg_nxt = op_erase ? ECCL_NV_ERASED : (cfg_r & op_data);
      end
   end

   always_ff @(posedge clk or negedge por_n) begin
      if (!por_n) begin
         cfg_r <= ECCL_NV_ERASED;
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

   assign rd_data  = arr_q[rd_idx];
   assign cfg_data = cfg_r;

endmodule : eccl_nv_store

// ==== logic/eccl_config_ctrl.sv ====
// Configuration latches, program control and AHB-Lite register slave
// Contract
// - Upper four configuration bits always read zero.
// - Without the security option the security disable bit reads one.
// - Security enabled refuses the expanded multiplexed mode.
// - Secure bootstrap reset erases array, RAM and configuration first.
// - Watchdog disable bit zero runs the watchdog, one stops it.
// - ROM enable clear unmaps the on-chip ROM to external space.
// - Single-chip mode keeps the ROM mapped regardless of ROM enable.
// - Array enable clear unmaps the 512-byte array to external space.
// - Configuration accepts only bulk erase: 0x06, write, 0x07, clear.
// - Any configuration erase also erases the whole array.
// - Configuration program or erase only in test or bootstrap mode.
// - Reset copies the stored byte into latches that drive config.
// - Stored byte changes take effect only after the next reset.
// - Config reads return latches; config programming hits stored byte.
// - Control bits: byte over row, erase, latch mode, high voltage.
// - Writing latch and high voltage together sets neither unless latch is already set.
// - Array reads are disconnected while programming is set up.
`timescale 1ns/1ns
module eccl_config_ctrl
   import eccl_pkg::*;
#(
   parameter int unsigned PROG_CYCLES = ECCL_PROG_CYCLES,
   parameter bit          SEC_OPTION  = 1'b1,
   parameter bit          CFG_LOCK    = 1'b1
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        por_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   input  wire logic [1:0]  mode_pins,
   output logic      [1:0]  op_mode,
   output logic             rom_enable,
   output logic             array_enable,
   output logic             watchdog_enable,
   output logic             security_active,
   output logic             ram_clear
);
   localparam logic [ECCL_CNT_W-1:0] CNT_LAST =
      ECCL_CNT_W'(PROG_CYCLES - 1);

   logic [1:0]            mode_sync;
   logic [7:0]            nv_rd_data;
   logic [7:0]            nv_cfg;

   eccl_seq_t             seq_r;
   eccl_seq_t             seq_nxt;
   logic [1:0]            wait_r;
   logic [1:0]            wait_nxt;
   eccl_mode_t            mode_r;
   eccl_mode_t            mode_nxt;
   logic [3:0]            cfg_lat_r;
   logic [3:0]            cfg_lat_nxt;
   logic                  rom_r;
   logic                  rom_nxt;
   logic                  arr_r;
   logic                  arr_nxt;
   logic                  wdog_r;
   logic                  wdog_nxt;
   logic                  sec_r;
   logic                  sec_nxt;
   logic                  ram_clr_r;
   logic                  ram_clr_nxt;

   logic                  accept;
   logic                  a_ok;
   logic                  dp_wr_r;
   logic                  dp_wr_nxt;
   logic                  rd_busy_r;
   logic                  rd_busy_nxt;
   logic [15:0]           dp_idx_r;
   logic [15:0]           dp_idx_nxt;
   logic [31:0]           hrdata_r;
   logic [31:0]           hrdata_nxt;
   logic                  dp_prog;
   logic                  dp_cfg;
   logic                  dp_stat;
   logic                  dp_arr;
   logic [7:0]            rd_byte;

   logic [7:0]            pc_r;
   logic [7:0]            pc_nxt;
   logic [7:0]            wr_val;
   logic                  tgt_v_r;
   logic                  tgt_v_nxt;
   logic                  tgt_cfg_r;
   logic                  tgt_cfg_nxt;
   logic [8:0]            tgt_idx_r;
   logic [8:0]            tgt_idx_nxt;
   logic [7:0]            tgt_dat_r;
   logic [7:0]            tgt_dat_nxt;
   logic [ECCL_CNT_W-1:0] cnt_r;
   logic [ECCL_CNT_W-1:0] cnt_nxt;
   logic                  done_r;
   logic                  done_nxt;
   logic                  commit;
   logic                  op_valid;
   logic                  op_cfg;
   logic                  op_erase;
   logic                  op_byte;
   logic                  op_row;

   eccl_sync2 #(
      .WIDTH (2)
   ) u_mode_sync (
      .clk   (hclk),
      .rst_n (hresetn),
      .d     (mode_pins),
      .q     (mode_sync)
   );

   eccl_nv_store #(
      .ARR_BYTES (ECCL_ARR_BYTES),
      .AW        (ECCL_ARR_AW)
   ) u_store (
      .clk      (hclk),
      .por_n    (por_n),
      .op_valid (op_valid),
      .op_cfg   (op_cfg),
      .op_erase (op_erase),
      .op_byte  (op_byte),
      .op_row   (op_row),
      .op_idx   (tgt_idx_r),
      .op_data  (tgt_dat_r),
      .rd_idx   (dp_idx_r[8:0]),
      .rd_data  (nv_rd_data),
      .cfg_data (nv_cfg)
   );

   // Reset sequence and working latches
   always_comb begin
      seq_nxt     = seq_r;
      wait_nxt    = wait_r;
      mode_nxt    = mode_r;
      cfg_lat_nxt = cfg_lat_r;
      rom_nxt     = rom_r;
      arr_nxt     = arr_r;
      wdog_nxt    = wdog_r;
      sec_nxt     = sec_r;
      ram_clr_nxt = 1'b0;
      unique case (seq_r)
         ECCL_WAIT: begin
            wait_nxt = wait_r + 2'h1;
            if (wait_r == ECCL_SYNC_WAIT) begin
               seq_nxt = ECCL_LOAD;
            end
         end
         ECCL_LOAD: begin
            cfg_lat_nxt = nv_cfg[3:0];
            if (!SEC_OPTION) begin
               cfg_lat_nxt[ECCL_CFG_SECURITY_DISABLE] = 1'b1;
            end
            mode_nxt = eccl_mode_t'(mode_sync);
            if (!cfg_lat_nxt[ECCL_CFG_SECURITY_DISABLE]
                && mode_nxt == ECCL_EXPANDED) begin
               mode_nxt = ECCL_SINGLE;
            end
            rom_nxt  = cfg_lat_nxt[ECCL_CFG_ROM_ENABLE]
                       | (mode_nxt == ECCL_SINGLE);
            arr_nxt  = cfg_lat_nxt[ECCL_CFG_ARRAY_ENABLE];
            wdog_nxt = ~cfg_lat_nxt[ECCL_CFG_WATCHDOG_DISABLE];
            sec_nxt  = ~cfg_lat_nxt[ECCL_CFG_SECURITY_DISABLE];
            if (sec_nxt && mode_nxt == ECCL_BOOT) begin
               seq_nxt     = ECCL_SCRUB;
               ram_clr_nxt = 1'b1;
            end else begin
               seq_nxt = ECCL_RUN;
            end
         end
         ECCL_SCRUB: begin
            seq_nxt = ECCL_LOAD;
         end
         ECCL_RUN: begin
            seq_nxt = ECCL_RUN;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         seq_r     <= ECCL_WAIT;
         wait_r    <= 2'h0;
         mode_r    <= ECCL_SINGLE;
         cfg_lat_r <= ECCL_CFG_LAT_RST;
         rom_r     <= 1'b1;
         arr_r     <= 1'b1;
         wdog_r    <= 1'b0;
         sec_r     <= 1'b0;
         ram_clr_r <= 1'b0;
      end else begin
         seq_r     <= seq_nxt;
         wait_r    <= wait_nxt;
         mode_r    <= mode_nxt;
         cfg_lat_r <= cfg_lat_nxt;
         rom_r     <= rom_nxt;
         arr_r     <= arr_nxt;
         wdog_r    <= wdog_nxt;
         sec_r     <= sec_nxt;
         ram_clr_r <= ram_clr_nxt;
      end
   end

   // Bus slave: writes zero wait, reads one wait state
   assign a_ok    = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'h0);
   assign accept  = hsel && htrans[1] && hready && (seq_r == ECCL_RUN);
   assign dp_prog = (dp_idx_r == ECCL_IDX_PROG);
   assign dp_cfg  = (dp_idx_r == ECCL_IDX_CFG);
   assign dp_stat = (dp_idx_r == ECCL_IDX_STAT);
   assign dp_arr  = (dp_idx_r[15:9] == ECCL_IDX_ARR[15:9]);

   always_comb begin
      rd_byte = 8'h00;
      if (dp_prog) begin
         rd_byte = pc_r & ECCL_PC_MASK;
      end else if (dp_cfg) begin
         rd_byte = {4'h0, cfg_lat_r};
      end else if (dp_stat) begin
         rd_byte = {2'h0, done_r, pc_r[ECCL_PC_HV] & ~done_r, tgt_v_r,
                    sec_r, mode_r};
      end else if (dp_arr && arr_r && !pc_r[ECCL_PC_LAT]) begin
         rd_byte = nv_rd_data;
      end
   end

   always_comb begin
      dp_wr_nxt   = accept && hwrite;
      rd_busy_nxt = accept && !hwrite;
      dp_idx_nxt  = dp_idx_r;
      if (accept) begin
         dp_idx_nxt = a_ok ? haddr[17:2] : ECCL_IDX_NONE;
      end
      hrdata_nxt = hrdata_r;
      if (rd_busy_r) begin
         hrdata_nxt = {24'h00_0000, rd_byte};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr_r   <= 1'b0;
         rd_busy_r <= 1'b0;
         dp_idx_r  <= ECCL_IDX_NONE;
         hrdata_r  <= 32'h0000_0000;
      end else begin
         dp_wr_r   <= dp_wr_nxt;
         rd_busy_r <= rd_busy_nxt;
         dp_idx_r  <= dp_idx_nxt;
         hrdata_r  <= hrdata_nxt;
      end
   end

   // Program control, target capture and high-voltage timer
   assign wr_val = hwdata[7:0] & ECCL_PC_MASK;

   always_comb begin
      pc_nxt      = pc_r;
      tgt_v_nxt   = tgt_v_r;
      tgt_cfg_nxt = tgt_cfg_r;
      tgt_idx_nxt = tgt_idx_r;
      tgt_dat_nxt = tgt_dat_r;
      cnt_nxt     = cnt_r;
      done_nxt    = done_r;
      if (dp_wr_r && dp_prog) begin
         pc_nxt = wr_val;
         if (wr_val[ECCL_PC_LAT] && wr_val[ECCL_PC_HV]
             && !pc_r[ECCL_PC_LAT]) begin
            pc_nxt[ECCL_PC_LAT] = 1'b0;
            pc_nxt[ECCL_PC_HV]  = 1'b0;
         end
      end
      if (dp_wr_r && pc_r[ECCL_PC_LAT] && !pc_r[ECCL_PC_HV]
          && (dp_arr || dp_cfg)) begin
         tgt_v_nxt   = 1'b1;
         tgt_cfg_nxt = dp_cfg;
         tgt_idx_nxt = dp_idx_r[8:0];
         tgt_dat_nxt = hwdata[7:0];
      end
      if (!pc_nxt[ECCL_PC_LAT]) begin
         tgt_v_nxt = 1'b0;
      end
      if (pc_r[ECCL_PC_HV] && tgt_v_r && !done_r) begin
         cnt_nxt = cnt_r + 1'b1;
         if (cnt_r == CNT_LAST) begin
            cnt_nxt  = '0;
            done_nxt = 1'b1;
         end
      end
      if (!pc_r[ECCL_PC_HV]) begin
         cnt_nxt  = '0;
         done_nxt = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pc_r      <= ECCL_PC_RST;
         tgt_v_r   <= 1'b0;
         tgt_cfg_r <= 1'b0;
         tgt_idx_r <= 9'h000;
         tgt_dat_r <= 8'h00;
         cnt_r     <= '0;
         done_r    <= 1'b0;
      end else begin
         pc_r      <= pc_nxt;
         tgt_v_r   <= tgt_v_nxt;
         tgt_cfg_r <= tgt_cfg_nxt;
         tgt_idx_r <= tgt_idx_nxt;
         tgt_dat_r <= tgt_dat_nxt;
         cnt_r     <= cnt_nxt;
         done_r    <= done_nxt;
      end
   end

   // Operation issued to the store
   assign commit = pc_r[ECCL_PC_HV] && tgt_v_r && !done_r
                   && (cnt_r == CNT_LAST);

   always_comb begin
      op_valid = 1'b0;
      op_cfg   = 1'b0;
      op_erase = 1'b0;
      op_byte  = 1'b0;
      op_row   = 1'b0;
      if (seq_r == ECCL_SCRUB) begin
         op_valid = 1'b1;
         op_cfg   = 1'b1;
         op_erase = 1'b1;
      end else if (commit) begin
         op_valid = 1'b1;
         op_cfg   = tgt_cfg_r;
         op_erase = pc_r[ECCL_PC_ERASE];
         op_byte  = pc_r[ECCL_PC_BYTE];
         op_row   = pc_r[ECCL_PC_ROW] & ~pc_r[ECCL_PC_BYTE];
         if (tgt_cfg_r && pc_r[ECCL_PC_ERASE]
             && (pc_r[ECCL_PC_BYTE] || pc_r[ECCL_PC_ROW])) begin
            op_valid = 1'b0;
         end
         if (tgt_cfg_r && CFG_LOCK
             && !(mode_r == ECCL_TEST || mode_r == ECCL_BOOT)) begin
            op_valid = 1'b0;
         end
      end
   end

   assign hreadyout       = (seq_r == ECCL_RUN) && !rd_busy_r;
   assign hresp           = 1'b0;
   assign hrdata          = hrdata_r;
   assign op_mode         = mode_r;
   assign rom_enable      = rom_r;
   assign array_enable    = arr_r;
   assign watchdog_enable = wdog_r;
   assign security_active = sec_r;
   assign ram_clear       = ram_clr_r;

   // Checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   cfg_read_upper_a: assert property (
      rd_busy_r && dp_cfg |=> hrdata[7:4] == 4'h0 && hrdata[3:0] == cfg_lat_r)
      else $error("config read upper bits not zero");
   security_disable_fixed_a: assert property (
      !SEC_OPTION && seq_r == ECCL_RUN |-> cfg_lat_r[ECCL_CFG_SECURITY_DISABLE])
      else $error("security bit not one without option");
   expanded_refused_a: assert property (
      seq_r == ECCL_RUN && security_active |-> op_mode != ECCL_EXPANDED)
      else $error("expanded mode selected while secure");
   secure_boot_a: assert property (
      seq_r == ECCL_LOAD && seq_nxt == ECCL_SCRUB
      |=> ram_clear && op_valid && op_erase && op_cfg ##1 seq_r == ECCL_LOAD)
      else $error("secure bootstrap scrub missing");
   watchdog_map_a: assert property (
      seq_r == ECCL_RUN |-> watchdog_enable == !cfg_lat_r[ECCL_CFG_WATCHDOG_DISABLE])
      else $error("watchdog enable mismatch");
   rom_map_a: assert property (
      seq_r == ECCL_RUN |-> rom_enable ==
      (cfg_lat_r[ECCL_CFG_ROM_ENABLE] || op_mode == ECCL_SINGLE))
      else $error("rom mapping mismatch");
   array_map_a: assert property (
      seq_r == ECCL_RUN && !array_enable && rd_busy_r && dp_arr
      |=> hrdata == 32'h0000_0000)
      else $error("disabled array returned data");
   cfg_lock_a: assert property (
      op_valid && op_cfg && seq_r == ECCL_RUN && CFG_LOCK
      |-> op_mode == ECCL_TEST || op_mode == ECCL_BOOT)
      else $error("config changed outside test or bootstrap");
   latch_stable_a: assert property (
      seq_r == ECCL_RUN ##1 seq_r == ECCL_RUN |-> $stable(cfg_lat_r))
      else $error("latches changed without reset");
   both_bits_a: assert property (
      dp_wr_r && dp_prog && hwdata[1:0] == 2'h3 && !pc_r[ECCL_PC_LAT]
      |=> pc_r[1:0] == 2'h0)
      else $error("latch and high voltage set together");
   array_disc_a: assert property (
      rd_busy_r && dp_arr && pc_r[ECCL_PC_LAT] |=> hrdata[7:0] == 8'h00)
      else $error("array read during programming");

   scrub_c: cover property (seq_r == ECCL_SCRUB);
   cfg_commit_c: cover property (commit && op_valid && op_cfg);
   arr_erase_c: cover property (commit && op_valid && op_erase && !op_cfg);
   cfg_read_c: cover property (rd_busy_r && dp_cfg);

endmodule : eccl_config_ctrl

// ==== bench/test_eeprom_config_latch_control.sv ====
// Self-checking bench for the configuration latch and program control block
`timescale 1ns/1ns
module test_eeprom_config_latch_control;
   import eccl_pkg::*;

   localparam int unsigned PROG = 8;
   localparam logic [31:0] A_CTRL = {14'h0000, ECCL_IDX_PROG, 2'b00};
   localparam logic [31:0] A_CFG  = {14'h0000, ECCL_IDX_CFG, 2'b00};
   localparam logic [31:0] A_ARR  = {14'h0000, ECCL_IDX_ARR, 2'b00};
   localparam logic [31:0] A_STAT = {14'h0000, ECCL_IDX_STAT, 2'b00};

   logic        hclk;
   logic        hresetn;
   logic        por_n;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hready;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic [1:0]  mode_pins;
   logic [1:0]  op_mode;
   logic        rom_enable;
   logic        array_enable;
   logic        watchdog_enable;
   logic        security_active;
   logic        ram_clear;
   logic [31:0] rd;
   int          miscompares;
   int          tests_run;
   int          scrubs;

   assign hready = hreadyout;

   eccl_config_ctrl #(.PROG_CYCLES(PROG), .SEC_OPTION(1'b1),
      .CFG_LOCK(1'b1)) i_dut (.hclk(hclk), .hresetn(hresetn),
      .por_n(por_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .mode_pins(mode_pins), .op_mode(op_mode), .rom_enable(rom_enable),
      .array_enable(array_enable), .watchdog_enable(watchdog_enable),
      .security_active(security_active), .ram_clear(ram_clear));

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   always @(posedge hclk) begin
      if (ram_clear === 1'b1) scrubs++;
   end

   task automatic print_verdict;
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s exp %h got %h", what, exp, got);
      end
   endtask : chk

   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 60);
      if (n >= 60) begin
         miscompares++;
         print_verdict();
      end
   endtask : wait_rdy

   task automatic xfer(logic w, logic [31:0] a, logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'b00;
      hsel   <= 1'b0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask : xfer

   task automatic wr(logic [31:0] a, logic [7:0] d);
      xfer(1'b1, a, {24'h00_0000, d});
   endtask : wr

   task automatic rdc(string what, logic [31:0] a, logic [7:0] e);
      xfer(1'b0, a, 32'h0000_0000);
      chk(what, {24'h00_0000, e}, rd);
      chk("response", 32'h0000_0000, {31'h0, hresp});
   endtask : rdc

   task automatic prog_op(logic [7:0] base, logic [31:0] a, logic [7:0] d);
      wr(A_CTRL, base);
      wr(a, d);
      wr(A_CTRL, base | 8'h01);
      repeat (PROG + 4) @(posedge hclk);
      wr(A_CTRL, 8'h00);
   endtask : prog_op

   task automatic do_reset(logic [1:0] m, logic [5:0] e, string t);
      @(posedge hclk);
      hresetn   <= 1'b0;
      mode_pins <= m;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      por_n   <= 1'b1;
      wait_rdy();
      chk("outputs", {30'h0, e[5:4]}, {30'h0, op_mode});
      chk("levels", {28'h0, e[3:0]},
         {28'h0, rom_enable, array_enable, watchdog_enable, security_active});
      $display("test %s done", t);
   endtask : do_reset

   initial begin
      #50000;
      miscompares++;
      print_verdict();
   end

   initial begin
      hresetn = 1'b0;
      por_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      mode_pins = 2'b00;
      miscompares = 0;
      tests_run = 0;
      scrubs = 0;
      do_reset(2'b00, 6'b00_1100, "erased start");
      rdc("config", A_CFG, 8'h0F);
      rdc("unmapped", 32'h0000_0000, 8'h00);
      wr(32'h0000_0000, 8'hAA);
      wr(A_CTRL, 8'h03);
      rdc("control", A_CTRL, 8'h00);
      wr(A_CTRL, 8'hFF);
      rdc("control", A_CTRL, 8'hDC);
      wr(A_CTRL, 8'h00);
      prog_op(8'h02, A_CFG, 8'h00);
      do_reset(2'b00, 6'b00_1100, "locked config");
      rdc("config", A_CFG, 8'h0F);
      wr(A_CTRL, 8'h02);
      wr(A_ARR, 8'h55);
      rdc("array busy", A_ARR, 8'h00);
      wr(A_CTRL, 8'h03);
      repeat (PROG + 4) @(posedge hclk);
      wr(A_CTRL, 8'h00);
      rdc("array", A_ARR, 8'h55);
      prog_op(8'h16, A_ARR, 8'h00);
      rdc("array", A_ARR, 8'hFF);
      prog_op(8'h02, A_ARR + 32'h4, 8'h12);
      wr(A_ARR + 32'h4, 8'h00);
      rdc("array", A_ARR + 32'h4, 8'h12);
      $display("test array done");
      do_reset(2'b11, 6'b11_1100, "test mode");
      prog_op(8'h02, A_CFG, 8'hF2);
      rdc("config", A_CFG, 8'h0F);
      do_reset(2'b01, 6'b00_1011, "secure expanded");
      rdc("config", A_CFG, 8'h02);
      rdc("array off", A_ARR + 32'h4, 8'h00);
      do_reset(2'b11, 6'b11_1011, "secure test");
      prog_op(8'h06, A_CFG, 8'h00);
      do_reset(2'b11, 6'b11_1100, "config erase");
      rdc("config", A_CFG, 8'h0F);
      rdc("array", A_ARR + 32'h4, 8'hFF);
      prog_op(8'h02, A_CFG, 8'h00);
      do_reset(2'b11, 6'b11_0011, "rom off");
      do_reset(2'b00, 6'b00_1011, "rom single");
      do_reset(2'b10, 6'b10_1100, "secure boot");
      chk("scrubs", 32'h0000_0001, scrubs);
      rdc("config", A_CFG, 8'h0F);
      rdc("status", A_STAT, 8'h02);
      print_verdict();
   end

endmodule : test_eeprom_config_latch_control
